// >>> rtl/cwsrc_regs.sv
// Register bank of the card wait and SDRAM refresh control block on APB,
// with the card sequencer and refresh engine beneath it.
// Assumes an APB master on CLOCK_I; CARD_WAIT_N_I is an asynchronous pin.
//
// Overview of operation
// - Wait mask off honours external wait, on ignores
// - Mask applies even with zero internal waits
// - Hold address field plus half cycle
// - Reserved bits always read back zero
// - Refresh enable bit 11 gates all refresh
// - Self refresh starts at once when selected
// - Auto refresh paced by timer and constant
// - Bit 8 selects auto-precharge or bank-active
// - Match flag set on counter equal constant
//
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/100ps
`include "cwsrc_params.svh"

module cwsrc_regs
	import cwsrc_pkg::*;
#(
	parameter int CNT_W = 8
)
(
	input  logic          CLOCK_I,
	input  logic          RST_I,
	input  logic          PSEL_I,
	input  logic          PENABLE_I,
	input  logic          PWRITE_I,
	input  logic [7:0]    PADDR_I,
	input  logic [31:0]   PWDATA_I,
	input  logic [3:0]    PSTRB_I,
	output logic [31:0]   PRDATA_O,
	output logic          PREADY_O,
	output logic          PSLVERR_O,
	input  logic          CARD_START_I,
	input  logic [3:0]    CARD_WAIT_CYCLES_I,
	input  logic          CARD_WAIT_N_I,
	output logic          CARD_STROBE_O,
	output logic          CARD_ADDR_VALID_O,
	output logic          CARD_BUSY_O,
	output logic          CARD_DONE_O,
	output logic          SDRAM_BANK_ACTIVE_O,
	output logic          SDRAM_AUTO_REFRESH_O,
	output logic          SDRAM_SELF_REFRESH_O
);
	cwsrc_cfg_if #(.CNT_W(CNT_W)) cfg ();

	// Reset words held as typed constants so their fields can be selected
	localparam cwsrc_word_t rst_card_wait  = `CWSRC_RST_CARD_WAIT;
	localparam cwsrc_word_t rst_sdram_ctrl = `CWSRC_RST_SDRAM_CTRL;
	localparam cwsrc_word_t rst_refresh_enable_csr   = `CWSRC_RST_REFRESH_ENABLE_CSR;

	// ==========================================================
	// Register state
	logic               wait_mask_ff;
	logic               nxt_wait_mask;
	logic [3:0]         hold_ff;
	logic [3:0]         nxt_hold;
	logic               refresh_enable_en_ff;
	logic               nxt_refresh_enable_en;
	logic               refresh_enable_mode_ff;
	logic               nxt_refresh_enable_mode;
	logic               bank_act_ff;
	logic               nxt_bank_act;
	logic               cmf_ff;
	logic               nxt_cmf;
	logic               cmf_armed_ff;
	logic               nxt_cmf_armed;
	logic [2:0]         cks_ff;
	logic [2:0]         nxt_cks;
	logic [CNT_W-1:0]   const_ff;
	logic [CNT_W-1:0]   nxt_const;
	cwsrc_word_t        prdata_ff;
	cwsrc_word_t        nxt_prdata;
	logic               pslverr_ff;
	logic               nxt_pslverr;
	logic               wait_s1_ff;
	logic               wait_s2_ff;

	// ==========================================================
	// Bus decode
	logic               setup;
	logic               access;
	logic               hit;
	logic               wr;
	logic               rd_csr;
	logic               key_ok;
	logic               cmf_clr;
	cwsrc_word_t        rd_val;
	cwsrc_word_t        wdata_eff;

	assign setup  = PSEL_I & ~PENABLE_I;
	assign access = PSEL_I & PENABLE_I;

	// Unused fields are never stored, so they read zero
	always_comb
	begin
		rd_val = 32'h0000_0000;
		hit    = 1'b1;
		case (PADDR_I)
			`CWSRC_OFF_CARD_WAIT:
			begin
				rd_val[`CWSRC_BIT_EXT_WAIT_MASK] = wait_mask_ff;
				rd_val[`CWSRC_HOLD_LSB +: `CWSRC_HOLD_W] = hold_ff;
			end
			`CWSRC_OFF_SDRAM_CTRL:
			begin
				rd_val[`CWSRC_BIT_REFRESH_ENABLE_EN]     = refresh_enable_en_ff;
				rd_val[`CWSRC_BIT_REFRESH_ENABLE_MODE]   = refresh_enable_mode_ff;
				rd_val[`CWSRC_BIT_BANK_ACTIVE] = bank_act_ff;
			end
			`CWSRC_OFF_REFRESH_ENABLE_CSR:
			begin
				rd_val[`CWSRC_BIT_CMF] = cmf_ff;
				rd_val[`CWSRC_CKS_LSB +: `CWSRC_CKS_W] = cks_ff;
			end
			`CWSRC_OFF_REFRESH_ENABLE_CNT:
				rd_val[CNT_W-1:0] = cfg.refresh_timer_counter;
			`CWSRC_OFF_REFRESH_ENABLE_CONST:
				rd_val[CNT_W-1:0] = const_ff;
			default:
				hit = 1'b0;
		endcase
	end

	// Lanes without a strobe keep the register's present contents
	genvar b;
	generate
		for (b = 0; b < 4; b++)
		begin : g_lane
			assign wdata_eff[8*b +: 8] = PSTRB_I[b] ? PWDATA_I[8*b +: 8]
			                                        : rd_val[8*b +: 8];
		end
	endgenerate

	assign wr     = access & PWRITE_I & hit;
	assign rd_csr = access & ~PWRITE_I & (PADDR_I == `CWSRC_OFF_REFRESH_ENABLE_CSR);
	// Key guards the timer control against stray writes
	assign key_ok = (PWDATA_I[`CWSRC_KEY_LSB +: 16] == `CWSRC_WR_KEY);
	// Clearing needs a prior read of the flag as one
	assign cmf_clr = wr && (PADDR_I == `CWSRC_OFF_REFRESH_ENABLE_CSR) && key_ok &&
	                 cmf_armed_ff && !wdata_eff[`CWSRC_BIT_CMF];

	// ==========================================================
	// Register next values
	always_comb
	begin
		nxt_wait_mask = wait_mask_ff;
		nxt_hold      = hold_ff;
		nxt_refresh_enable_en   = refresh_enable_en_ff;
		nxt_refresh_enable_mode = refresh_enable_mode_ff;
		nxt_bank_act  = bank_act_ff;
		nxt_cks       = cks_ff;
		nxt_const     = const_ff;
		if (wr)
		begin
			case (PADDR_I)
				`CWSRC_OFF_CARD_WAIT:
				begin
					nxt_wait_mask = wdata_eff[`CWSRC_BIT_EXT_WAIT_MASK];
					nxt_hold = wdata_eff[`CWSRC_HOLD_LSB +: `CWSRC_HOLD_W];
				end
				`CWSRC_OFF_SDRAM_CTRL:
				begin
					nxt_refresh_enable_en   = wdata_eff[`CWSRC_BIT_REFRESH_ENABLE_EN];
					nxt_refresh_enable_mode = wdata_eff[`CWSRC_BIT_REFRESH_ENABLE_MODE];
					// Zero auto-precharge, one bank-active
					nxt_bank_act  = wdata_eff[`CWSRC_BIT_BANK_ACTIVE];
				end
				`CWSRC_OFF_REFRESH_ENABLE_CSR:
				begin
					if (key_ok)
						nxt_cks = wdata_eff[`CWSRC_CKS_LSB +: `CWSRC_CKS_W];
				end
				`CWSRC_OFF_REFRESH_ENABLE_CONST:
					nxt_const = wdata_eff[CNT_W-1:0];
				default:
				begin
					nxt_cks = cks_ff;
				end
			endcase
		end
		// A match in the clearing cycle wins
		nxt_cmf       = cfg.match | (cmf_ff & ~cmf_clr);
		nxt_cmf_armed = (rd_csr & cmf_ff) | (cmf_armed_ff & ~cmf_clr);
		// Read data is captured in the setup cycle
		nxt_prdata    = prdata_ff;
		nxt_pslverr   = pslverr_ff;
		if (setup)
		begin
			nxt_prdata  = (!PWRITE_I && hit) ? rd_val : 32'h0000_0000;
			nxt_pslverr = ~hit;
		end
	end

	always_ff @(posedge CLOCK_I)
	begin
		if (RST_I)
		begin
			wait_mask_ff <= rst_card_wait[`CWSRC_BIT_EXT_WAIT_MASK];
			hold_ff      <= rst_card_wait[`CWSRC_HOLD_LSB +: `CWSRC_HOLD_W];
			refresh_enable_en_ff   <= rst_sdram_ctrl[`CWSRC_BIT_REFRESH_ENABLE_EN];
			refresh_enable_mode_ff <= rst_sdram_ctrl[`CWSRC_BIT_REFRESH_ENABLE_MODE];
			bank_act_ff  <= rst_sdram_ctrl[`CWSRC_BIT_BANK_ACTIVE];
			cmf_ff       <= rst_refresh_enable_csr[`CWSRC_BIT_CMF];
			cmf_armed_ff <= 1'b0;
			cks_ff       <= rst_refresh_enable_csr[`CWSRC_CKS_LSB +: `CWSRC_CKS_W];
			const_ff     <= '0;
			prdata_ff    <= 32'h0000_0000;
			pslverr_ff   <= 1'b0;
		end
		else
		begin
			wait_mask_ff <= nxt_wait_mask;
			hold_ff      <= nxt_hold;
			refresh_enable_en_ff   <= nxt_refresh_enable_en;
			refresh_enable_mode_ff <= nxt_refresh_enable_mode;
			bank_act_ff  <= nxt_bank_act;
			cmf_ff       <= nxt_cmf;
			cmf_armed_ff <= nxt_cmf_armed;
			cks_ff       <= nxt_cks;
			const_ff     <= nxt_const;
			prdata_ff    <= nxt_prdata;
			pslverr_ff   <= nxt_pslverr;
		end
	end

	// ==========================================================
	// External wait pin synchroniser, active low at the pin
	always_ff @(posedge CLOCK_I)
	begin
		if (RST_I)
		begin
			wait_s1_ff <= 1'b1;
			wait_s2_ff <= 1'b1;
		end
		else
		begin
			wait_s1_ff <= CARD_WAIT_N_I;
			wait_s2_ff <= wait_s1_ff;
		end
	end

	// ==========================================================
	// Settings toward the engines
	assign cfg.ext_wait_mask          = wait_mask_ff;
	assign cfg.strobe_to_addr_hold    = hold_ff;
	assign cfg.refresh_enable         = refresh_enable_en_ff;
	assign cfg.refresh_mode_select    = refresh_enable_mode_ff;
	assign cfg.clk_sel                = cks_ff;
	assign cfg.cnt_wr                 = wr && (PADDR_I == `CWSRC_OFF_REFRESH_ENABLE_CNT);
	assign cfg.cnt_wdata              = wdata_eff[CNT_W-1:0];
	assign cfg.refresh_timer_constant = const_ff;

	cwsrc_card_seq u_card
	(
		.clk_i         (CLOCK_I),
		.rst_i         (RST_I),
		.start_i       (CARD_START_I),
		.wait_cycles_i (CARD_WAIT_CYCLES_I),
		.ext_wait_i    (~wait_s2_ff),
		.cfg           (cfg),
		.strobe_o      (CARD_STROBE_O),
		.addr_valid_o  (CARD_ADDR_VALID_O),
		.busy_o        (CARD_BUSY_O),
		.done_o        (CARD_DONE_O)
	);

	cwsrc_refresh #(.CNT_W(CNT_W)) u_refresh
	(
		.clk_i          (CLOCK_I),
		.rst_i          (RST_I),
		.cfg            (cfg),
		.auto_refresh_o (SDRAM_AUTO_REFRESH_O),
		.self_refresh_o (SDRAM_SELF_REFRESH_O)
	);

	// ==========================================================
	// Bus answer: zero wait states
	assign PREADY_O            = access;
	assign PRDATA_O            = prdata_ff;
	assign PSLVERR_O           = access & pslverr_ff;
	assign SDRAM_BANK_ACTIVE_O = bank_act_ff;
endmodule // cwsrc_regs

// >>> rtl/cwsrc_params.svh
// Offsets, field positions, reset values and timing counts of the
// card wait and SDRAM refresh control block.
// Assumes inclusion by bare name from every file of the block.
`ifndef CWSRC_PARAMS_SVH
`define CWSRC_PARAMS_SVH

// ==========================================================
// Register byte offsets
`define CWSRC_OFF_CARD_WAIT     8'h00
`define CWSRC_OFF_SDRAM_CTRL    8'h04
`define CWSRC_OFF_REFRESH_ENABLE_CSR      8'h08
`define CWSRC_OFF_REFRESH_ENABLE_CNT      8'h0C
`define CWSRC_OFF_REFRESH_ENABLE_CONST    8'h10

// ==========================================================
// Card wait control fields
`define CWSRC_BIT_EXT_WAIT_MASK 6
`define CWSRC_HOLD_LSB          0
`define CWSRC_HOLD_W            4

// ==========================================================
// SDRAM control fields
`define CWSRC_BIT_REFRESH_ENABLE_EN       11
`define CWSRC_BIT_REFRESH_ENABLE_MODE     10
`define CWSRC_BIT_BANK_ACTIVE   8

// ==========================================================
// Refresh timer control/status fields
`define CWSRC_BIT_CMF           7
`define CWSRC_CKS_LSB           3
`define CWSRC_CKS_W             3
`define CWSRC_KEY_LSB           16
`define CWSRC_WR_KEY            16'hA55A

// ==========================================================
// Reset values
`define CWSRC_RST_CARD_WAIT     32'h0000_0000
`define CWSRC_RST_SDRAM_CTRL    32'h0000_0000
`define CWSRC_RST_REFRESH_ENABLE_CSR      32'h0000_0000

// ==========================================================
// Prescaler widths: log2 of each timer clock divisor
`define CWSRC_PRESC_W           12
`define CWSRC_DIV_LOG2_1        4'h2
`define CWSRC_DIV_LOG2_2        4'h4
`define CWSRC_DIV_LOG2_3        4'h6
`define CWSRC_DIV_LOG2_4        4'h8
`define CWSRC_DIV_LOG2_5        4'hA
`define CWSRC_DIV_LOG2_6        4'hB
`define CWSRC_DIV_LOG2_7        4'hC

`endif

// >>> rtl/cwsrc_pkg.sv
// Types shared by the card wait and SDRAM refresh control block.
// Assumes nothing of its surroundings.
package cwsrc_pkg;

	// ==========================================================
	// Card access sequencer states
	typedef enum logic [1:0]
	{
		CWSRC_ST_IDLE   = 2'b00,
		CWSRC_ST_STROBE = 2'b01,
		CWSRC_ST_HOLD   = 2'b10
	} cwsrc_card_st_e;

	typedef logic [31:0] cwsrc_word_t;

endpackage

// >>> rtl/cwsrc_cfg_if.sv
// Configuration and timer signals between the register bank and the
// card sequencer and refresh engine.
// Assumes one clock domain; the register bank drives all settings.
`timescale 1ns/100ps

interface cwsrc_cfg_if
#(
	parameter int CNT_W = 8
);
	logic                ext_wait_mask;
	logic [3:0]          strobe_to_addr_hold;
	logic                refresh_enable;
	logic                refresh_mode_select;
	logic [2:0]          clk_sel;
	logic                cnt_wr;
	logic [CNT_W-1:0]    cnt_wdata;
	logic [CNT_W-1:0]    refresh_timer_constant;
	logic [CNT_W-1:0]    refresh_timer_counter;
	logic                match;

	modport regs
	(
		output ext_wait_mask,
		output strobe_to_addr_hold,
		output refresh_enable,
		output refresh_mode_select,
		output clk_sel,
		output cnt_wr,
		output cnt_wdata,
		output refresh_timer_constant,
		input  refresh_timer_counter,
		input  match
	);

	modport card
	(
		input  ext_wait_mask,
		input  strobe_to_addr_hold
	);

	modport refresh
	(
		input  refresh_enable,
		input  refresh_mode_select,
		input  clk_sel,
		input  cnt_wr,
		input  cnt_wdata,
		input  refresh_timer_constant,
		output refresh_timer_counter,
		output match
	);
endinterface // cwsrc_cfg_if

// >>> rtl/cwsrc_card_seq.sv
// Card access sequencer: strobe with wait stretching, then address hold.
// Assumes a synchronised, active-high external wait and a start pulse.
`timescale 1ns/100ps
`include "cwsrc_params.svh"

module cwsrc_card_seq
	import cwsrc_pkg::*;
(
	input  logic          clk_i,
	input  logic          rst_i,
	input  logic          start_i,
	input  logic [3:0]    wait_cycles_i,
	input  logic          ext_wait_i,
	cwsrc_cfg_if.card     cfg,
	output logic          strobe_o,
	output logic          addr_valid_o,
	output logic          busy_o,
	output logic          done_o
);
	cwsrc_card_st_e state_ff;
	cwsrc_card_st_e nxt_state;
	logic [3:0]     cnt_ff;
	logic [3:0]     nxt_cnt;
	logic           done_ff;
	logic           nxt_done;
	logic           stretch;

	// ==========================================================
	// Next state
	always_comb
	begin
		// Mask applies even with zero internal waits
		stretch   = ext_wait_i & ~cfg.ext_wait_mask;
		nxt_state = state_ff;
		nxt_cnt   = cnt_ff;
		nxt_done  = 1'b0;
		case (state_ff)
			CWSRC_ST_IDLE:
			begin
				if (start_i)
				begin
					nxt_state = CWSRC_ST_STROBE;
					nxt_cnt   = wait_cycles_i;
				end
			end
			CWSRC_ST_STROBE:
			begin
				if (cnt_ff != 4'h0)
					nxt_cnt = cnt_ff - 4'h1;
				else if (!stretch)
				begin
					// Hold of field+1 cycles covers field+0.5
					nxt_state = CWSRC_ST_HOLD;
					nxt_cnt   = cfg.strobe_to_addr_hold;
				end
			end
			CWSRC_ST_HOLD:
			begin
				if (cnt_ff != 4'h0)
					nxt_cnt = cnt_ff - 4'h1;
				else
				begin
					nxt_state = CWSRC_ST_IDLE;
					nxt_done  = 1'b1;
				end
			end
			default:
			begin
				nxt_state = CWSRC_ST_IDLE;
				nxt_cnt   = 4'h0;
			end
		endcase
	end

	// ==========================================================
	// Registers
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_ff <= CWSRC_ST_IDLE;
			cnt_ff   <= 4'h0;
			done_ff  <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			cnt_ff   <= nxt_cnt;
			done_ff  <= nxt_done;
		end
	end

	assign strobe_o     = (state_ff == CWSRC_ST_STROBE);
	assign addr_valid_o = (state_ff != CWSRC_ST_IDLE);
	assign busy_o       = (state_ff != CWSRC_ST_IDLE);
	assign done_o       = done_ff;
endmodule // cwsrc_card_seq

// >>> rtl/cwsrc_refresh.sv
// Refresh engine: prescaled timer, compare match, auto and self refresh.
// Assumes settings from the register bank on the same clock.
`timescale 1ns/100ps
`include "cwsrc_params.svh"

module cwsrc_refresh
	import cwsrc_pkg::*;
#(
	parameter int CNT_W = 8
)
(
	input  logic          clk_i,
	input  logic          rst_i,
	cwsrc_cfg_if.refresh  cfg,
	output logic          auto_refresh_o,
	output logic          self_refresh_o
);
	logic [`CWSRC_PRESC_W-1:0] presc_ff;
	logic [`CWSRC_PRESC_W-1:0] nxt_presc;
	logic [CNT_W-1:0]          cnt_ff;
	logic [CNT_W-1:0]          nxt_cnt;
	logic                      auto_ff;
	logic                      nxt_auto;
	logic                      self_ff;
	logic                      nxt_self;
	logic                      tick;
	logic                      match;
	logic [3:0]                div_log2;
	logic [`CWSRC_PRESC_W-1:0] low_mask;

	// ==========================================================
	// Divisor selection; zero stops the timer
	always_comb
	begin
		case (cfg.clk_sel)
			3'h1:    div_log2 = `CWSRC_DIV_LOG2_1;
			3'h2:    div_log2 = `CWSRC_DIV_LOG2_2;
			3'h3:    div_log2 = `CWSRC_DIV_LOG2_3;
			3'h4:    div_log2 = `CWSRC_DIV_LOG2_4;
			3'h5:    div_log2 = `CWSRC_DIV_LOG2_5;
			3'h6:    div_log2 = `CWSRC_DIV_LOG2_6;
			3'h7:    div_log2 = `CWSRC_DIV_LOG2_7;
			default: div_log2 = 4'h0;
		endcase
	end

	// ==========================================================
	// Timer and refresh requests
	always_comb
	begin
		low_mask  = ~({`CWSRC_PRESC_W{1'b1}} << div_log2);
		nxt_presc = presc_ff + {{(`CWSRC_PRESC_W-1){1'b0}}, 1'b1};
		tick      = (div_log2 != 4'h0) &&
		            ((presc_ff & low_mask) == low_mask);
		// Compare match is the auto refresh trigger
		match     = tick && !cfg.cnt_wr &&
		            (cnt_ff == cfg.refresh_timer_constant);
		nxt_cnt   = cnt_ff;
		if (cfg.cnt_wr)
			nxt_cnt = cfg.cnt_wdata;
		else if (match)
			nxt_cnt = '0;
		else if (tick)
			nxt_cnt = cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
		// Auto refresh paced by the timer, only when enabled
		nxt_auto  = match & cfg.refresh_enable & ~cfg.refresh_mode_select;
		// Self refresh entered at once, no timer wait
		nxt_self  = cfg.refresh_enable & cfg.refresh_mode_select;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			presc_ff <= '0;
			cnt_ff   <= '0;
			auto_ff  <= 1'b0;
			self_ff  <= 1'b0;
		end
		else
		begin
			presc_ff <= nxt_presc;
			cnt_ff   <= nxt_cnt;
			auto_ff  <= nxt_auto;
			self_ff  <= nxt_self;
		end
	end

	assign cfg.refresh_timer_counter = cnt_ff;
	assign cfg.match                 = match;
	assign auto_refresh_o            = auto_ff;
	assign self_refresh_o            = self_ff;
endmodule // cwsrc_refresh

// >>> bench/cwsrc_regs_asserts.sv
// Checker for the card wait and SDRAM refresh control block.
// Assumes it is bound to cwsrc_regs and sees only its ports.
`timescale 1ns/100ps

module cwsrc_regs_asserts
	import cwsrc_pkg::*;
#(
	parameter int CNT_W = 8
)
(
	input logic        CLOCK_I,
	input logic        RST_I,
	input logic        PSEL_I,
	input logic        PENABLE_I,
	input logic        PWRITE_I,
	input logic [7:0]  PADDR_I,
	input logic [31:0] PWDATA_I,
	input logic [3:0]  PSTRB_I,
	input logic [31:0] PRDATA_O,
	input logic        PREADY_O,
	input logic        PSLVERR_O,
	input logic        CARD_START_I,
	input logic [3:0]  CARD_WAIT_CYCLES_I,
	input logic        CARD_WAIT_N_I,
	input logic        CARD_STROBE_O,
	input logic        CARD_ADDR_VALID_O,
	input logic        CARD_BUSY_O,
	input logic        CARD_DONE_O,
	input logic        SDRAM_BANK_ACTIVE_O,
	input logic        SDRAM_AUTO_REFRESH_O,
	input logic        SDRAM_SELF_REFRESH_O
);
	// ==========================================================
	// Shadow of the written settings and phase length counters
	logic       wr00, wr04, rd00, rd04, self_w, auto_w;
	logic       en_ff, mode_ff, mask_ff, nxt_en, nxt_mode, nxt_mask;
	logic [3:0] hold_ff, n_ff, nxt_hold, nxt_n;
	logic [5:0] scnt_ff, hcnt_ff, nxt_scnt, nxt_hcnt;

	assign wr00 = PSEL_I & PENABLE_I & PWRITE_I & (PADDR_I == 8'h00);
	assign wr04 = PSEL_I & PENABLE_I & PWRITE_I & (PADDR_I == 8'h04);
	assign rd00 = PSEL_I & PENABLE_I & ~PWRITE_I & (PADDR_I == 8'h00);
	assign rd04 = PSEL_I & PENABLE_I & ~PWRITE_I & (PADDR_I == 8'h04);
	assign self_w = en_ff & mode_ff;
	assign auto_w = en_ff & ~mode_ff;

	always_comb
	begin
		nxt_en = (wr04 & PSTRB_I[1]) ? PWDATA_I[11] : en_ff;
		nxt_mode = (wr04 & PSTRB_I[1]) ? PWDATA_I[10] : mode_ff;
		nxt_mask = (wr00 & PSTRB_I[0]) ? PWDATA_I[6] : mask_ff;
		nxt_hold = (wr00 & PSTRB_I[0]) ? PWDATA_I[3:0] : hold_ff;
		nxt_n = (CARD_START_I & ~CARD_BUSY_O) ? CARD_WAIT_CYCLES_I : n_ff;
		nxt_scnt = CARD_STROBE_O ? scnt_ff + 6'h01 : 6'h00;
		nxt_hcnt = (CARD_ADDR_VALID_O & ~CARD_STROBE_O) ? hcnt_ff + 6'h01 : 6'h00;
		if (RST_I)
		begin
			nxt_en = 1'b0;
			nxt_mode = 1'b0;
			nxt_mask = 1'b0;
			nxt_hold = 4'h0;
		end
	end

	always_ff @(posedge CLOCK_I)
	begin
		en_ff <= nxt_en;
		mode_ff <= nxt_mode;
		mask_ff <= nxt_mask;
		hold_ff <= nxt_hold;
		n_ff <= nxt_n;
		scnt_ff <= nxt_scnt;
		hcnt_ff <= nxt_hcnt;
	end

	// ==========================================================
	// Properties
	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (RST_I);

	a_mask_strobe_len: assert property ($fell(CARD_STROBE_O) && mask_ff
		|-> scnt_ff == {2'b00, n_ff} + 6'h01) else $error("strobe length off");
	a_strobe_min_len: assert property ($fell(CARD_STROBE_O)
		|-> scnt_ff >= {2'b00, n_ff} + 6'h01) else $error("strobe too short");
	a_hold_len: assert property ($fell(CARD_ADDR_VALID_O)
		|-> hcnt_ff == {2'b00, hold_ff} + 6'h01) else $error("hold length off");
	a_hold_follows: assert property ($fell(CARD_STROBE_O)
		|-> CARD_ADDR_VALID_O) else $error("no address hold");
	a_self_follow: assert property (!$past(RST_I)
		|-> SDRAM_SELF_REFRESH_O == $past(self_w)) else $error("self refresh off");
	a_auto_gated: assert property (SDRAM_AUTO_REFRESH_O
		|-> $past(auto_w) || $past(auto_w, 2)) else $error("auto refresh ungated");
	a_auto_pulse: assert property (SDRAM_AUTO_REFRESH_O
		|=> !SDRAM_AUTO_REFRESH_O) else $error("auto refresh too long");
	a_bank_write: assert property (wr04 && PSTRB_I[1]
		|=> SDRAM_BANK_ACTIVE_O == $past(PWDATA_I[8])) else $error("bank mode");
	a_bank_hold: assert property (!(wr04 && PSTRB_I[1])
		|=> $stable(SDRAM_BANK_ACTIVE_O)) else $error("bank mode moved");
	a_resv_sdram: assert property (rd04 |-> PRDATA_O[31:12] == 20'h0
		&& !PRDATA_O[9] && PRDATA_O[7:0] == 8'h00) else $error("sdram resv");
	a_resv_card: assert property (rd00 |-> PRDATA_O[31:7] == 25'h0
		&& PRDATA_O[5:4] == 2'b00) else $error("card resv");
endmodule // cwsrc_regs_asserts

bind cwsrc_regs cwsrc_regs_asserts #(.CNT_W(CNT_W)) u_chk
(
	.CLOCK_I(CLOCK_I), .RST_I(RST_I), .PSEL_I(PSEL_I),
	.PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
	.PWDATA_I(PWDATA_I), .PSTRB_I(PSTRB_I), .PRDATA_O(PRDATA_O),
	.PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
	.CARD_START_I(CARD_START_I), .CARD_WAIT_CYCLES_I(CARD_WAIT_CYCLES_I),
	.CARD_WAIT_N_I(CARD_WAIT_N_I), .CARD_STROBE_O(CARD_STROBE_O),
	.CARD_ADDR_VALID_O(CARD_ADDR_VALID_O), .CARD_BUSY_O(CARD_BUSY_O),
	.CARD_DONE_O(CARD_DONE_O), .SDRAM_BANK_ACTIVE_O(SDRAM_BANK_ACTIVE_O),
	.SDRAM_AUTO_REFRESH_O(SDRAM_AUTO_REFRESH_O),
	.SDRAM_SELF_REFRESH_O(SDRAM_SELF_REFRESH_O)
);

// >>> bench/cwsrc_card_model.sv
// Card device model: holds its wait pin low for a while when told busy.
// Assumes the bench pulses go_i ahead of an access; pin is pulled up.
`timescale 1ns/100ps

module cwsrc_card_model
#(
	parameter int BUSY_LEN = 6
)
(
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic go_i,
	output wire logic wait_n_o
);
	int cnt_ff;

	always_ff @(posedge clk_i)
		cnt_ff <= rst_i ? 0 : go_i ? BUSY_LEN : (cnt_ff > 0) ? cnt_ff - 1 : 0;

	// Released pin reads high through its pull-up
	assign wait_n_o = !(cnt_ff > 0);
endmodule // cwsrc_card_model

// >>> bench/tb_top.sv
// Self-checking bench of the card wait and SDRAM refresh control block.
// Assumes the checker is bound to cwsrc_regs by its own file.
`timescale 1ns/100ps

module tb_top;
	import cwsrc_pkg::*;
	logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
	logic        pwrite = 1'b0, start = 1'b0, go = 1'b0, err;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rdat;
	logic [3:0]  wcyc = 4'h0, pstrb = 4'hF;
	logic        pready, pslverr, wait_n, strobe, avalid, busy, done;
	logic        bank, arf, srf;
	int          num_errors = 0, cmp_count = 0;

	always #12.5 clk = ~clk;

	cwsrc_regs u_dut (.CLOCK_I(clk), .RST_I(rst), .PSEL_I(psel),
		.PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
		.PWDATA_I(pwdata), .PSTRB_I(pstrb), .PRDATA_O(prdata),
		.PREADY_O(pready), .PSLVERR_O(pslverr), .CARD_START_I(start),
		.CARD_WAIT_CYCLES_I(wcyc), .CARD_WAIT_N_I(wait_n),
		.CARD_STROBE_O(strobe), .CARD_ADDR_VALID_O(avalid),
		.CARD_BUSY_O(busy), .CARD_DONE_O(done), .SDRAM_BANK_ACTIVE_O(bank),
		.SDRAM_AUTO_REFRESH_O(arf), .SDRAM_SELF_REFRESH_O(srf));

	cwsrc_card_model u_card (.clk_i(clk), .rst_i(rst), .go_i(go),
		.wait_n_o(wait_n));

	// ==========================================================
	// Shared tasks
	task end_sim;
		$display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("unexpected at %0t: seen %h, expected %h", $time, seen, exp);
		end
	endtask

	// Holds the request until ready is seen at a rising edge
	task apb(input logic is_wr, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= is_wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (i = 0; i < 16; i++)
		begin
			@(posedge clk);
			if (pready === 1'b1)
				break;
		end
		if (i == 16)
		begin
			num_errors++;
			end_sim();
		end
		rdat = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task rdc(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rdat, exp);
	endtask

	task arf_gap(output int g);
		for (g = 1; g < 64; g++)
		begin
			@(negedge clk);
			if (arf === 1'b1)
				break;
		end
		if (g == 64)
		begin
			num_errors++;
			end_sim();
		end
	endtask

	// ==========================================================
	// Scenarios
	task t_reset;
		rdc(8'h00, 32'h0);
		rdc(8'h04, 32'h0);
		chk(bank, 1'b0);
		chk(srf, 1'b0);
	endtask

	task t_resv;
		wr(8'h00, 32'hFFFF_FFFF);
		rdc(8'h00, 32'h0000_004F);
		wr(8'h04, 32'hFFFF_FFFF);
		rdc(8'h04, 32'h0000_0D00);
		wr(8'h04, 32'h0);
		wr(8'h40, 32'h0000_0001);
		chk(err, 1'b1);
		rdc(8'h40, 32'h0);
	endtask

	task t_bank;
		wr(8'h04, 32'h0000_0100);
		@(posedge clk);
		chk(bank, 1'b1);
		rdc(8'h04, 32'h0000_0100);
		// Lane 1 not strobed: the bank mode bit must stay
		pstrb <= 4'h1;
		wr(8'h04, 32'h0);
		pstrb <= 4'hF;
		rdc(8'h04, 32'h0000_0100);
		wr(8'h04, 32'h0);
		@(posedge clk);
		chk(bank, 1'b0);
	endtask

	task t_self;
		wr(8'h04, 32'h0000_0400);
		repeat (2) @(posedge clk);
		chk(srf, 1'b0);
		wr(8'h04, 32'h0000_0C00);
		repeat (2) @(posedge clk);
		chk(srf, 1'b1);
		chk(arf, 1'b0);
		wr(8'h04, 32'h0);
		repeat (2) @(posedge clk);
		chk(srf, 1'b0);
	endtask

	// Constant 2, divide by 4: a match every third tick
	task t_auto;
		int i, n;
		wr(8'h10, 32'h0000_0002);
		wr(8'h08, 32'hA55A_0008);
		n = 0;
		for (i = 0; i < 60; i++)
		begin
			@(negedge clk);
			if (arf === 1'b1)
				n++;
		end
		chk(n, 0);
		wr(8'h04, 32'h0000_0800);
		arf_gap(n);
		arf_gap(n);
		chk(n, (2 + 1) * 4);
		rdc(8'h08, 32'h0000_0088);
		// Stop the timer first so no match can fall in the clearing cycle
		wr(8'h08, 32'hA55A_0080);
		wr(8'h08, 32'hA55A_0000);
		rdc(8'h08, 32'h0);
		wr(8'h04, 32'h0);
	endtask

	task card(input logic [31:0] c, input logic [3:0] n, input logic dev,
		output int s, output int h);
		int i;
		wr(8'h00, c);
		go <= dev;
		@(posedge clk);
		go <= 1'b0;
		@(posedge clk);
		start <= 1'b1;
		wcyc <= n;
		@(posedge clk);
		start <= 1'b0;
		s = 0;
		h = 0;
		for (i = 0; i < 200 && done !== 1'b1; i++)
		begin
			@(negedge clk);
			s += (strobe === 1'b1);
			h += (avalid === 1'b1 && strobe !== 1'b1);
		end
		if (i == 200)
		begin
			num_errors++;
			end_sim();
		end
	endtask

	task t_card;
		int s, h;
		card(32'h0000_0043, 4'h0, 1'b1, s, h);
		chk(s, 1);
		chk(h, 4);
		card(32'h0000_000F, 4'h0, 1'b1, s, h);
		chk(s > 1, 1'b1);
		chk(h, 16);
		card(32'h0000_0040, 4'h2, 1'b1, s, h);
		chk(s, 3);
		chk(h, 1);
	endtask

	initial
	begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_resv();
		t_bank();
		t_self();
		t_auto();
		t_card();
		end_sim();
	end
endmodule // tb_top
